//--- logic/pfb_pkg.sv
// Package of constants and types for the parallel flash bus interface.
package pfb_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BLOCK_W = 8;
    localparam int BLOCK_LSB = ADDR_W - BLOCK_W;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] STATUS_READY_BIT = 8'h80;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_WORD_PROG = 8'h40;
    localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam int CLK_MHZ = 25;
    localparam int RESET_ABORT_US = 25;
    localparam int RESET_ABORT_CYC = RESET_ABORT_US * CLK_MHZ;
    localparam int PROG_TIME_CYC = 64;
    localparam int ERASE_TIME_CYC = 256;
    localparam int BUSY_W = 12;

    typedef enum logic [2:0] {
        PFB_OP_RESET   = 3'b000,
        PFB_OP_STANDBY = 3'b001,
        PFB_OP_DISABLE = 3'b011,
        PFB_OP_READ    = 3'b010,
        PFB_OP_WRITE   = 3'b110
    } pfb_op_t;

    typedef enum logic [1:0] {
        PFB_SEQ_IDLE  = 2'b00,
        PFB_SEQ_ARMED = 2'b01,
        PFB_SEQ_BUSY  = 2'b11,
        PFB_SEQ_ABORT = 2'b10
    } pfb_seq_t;

endpackage : pfb_pkg

//--- logic/pfb_cmd_if.sv
// Interface carrying captured write commands to the write sequencer.
`timescale 1ns/1ps
interface pfb_cmd_if;
    logic                        wr_pulse;
    logic [pfb_pkg::ADDR_W-1:0]  wr_addr;
    logic [pfb_pkg::DATA_W-1:0]  wr_data;
    logic                        hard_reset;
    logic                        busy;
    logic                        aborted;
    logic [7:0]                  status;

    modport front (output wr_pulse, output wr_addr, output wr_data, output hard_reset,
                   input busy, input aborted, input status);
    modport seq (input wr_pulse, input wr_addr, input wr_data, input hard_reset,
                 output busy, output aborted, output status);
endinterface : pfb_cmd_if

//--- logic/pfb_write_seq.sv
// Embedded write sequencer: command decoding and internally timed operations.
`timescale 1ns/1ps
module pfb_write_seq (
    input  wire logic ref_clk_in,
    input  wire logic resetn_in,
    pfb_cmd_if.seq    cmd
);
    // =========================================================
    // Command decode
    // =========================================================
    pfb_pkg::pfb_seq_t state_q;
    pfb_pkg::pfb_seq_t state_d;
    logic [pfb_pkg::BUSY_W-1:0] cnt_q;
    logic [pfb_pkg::BUSY_W-1:0] cnt_d;
    logic [7:0]                 status_q;
    logic [7:0]                 status_d;
    logic                       erase_q;
    logic                       erase_d;
    logic                       aborted_q;
    logic                       aborted_d;
    wire  [7:0]                 code = cmd.wr_data[7:0];
    wire                        is_prog  = (code == pfb_pkg::CMD_WORD_PROG) || (code == pfb_pkg::CMD_WORD_PROG_ALT);
    wire                        is_erase = code == pfb_pkg::CMD_BLOCK_ERASE;
    wire                        cnt_done = cnt_q == '0;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        status_d  = status_q;
        erase_d   = erase_q;
        aborted_d = aborted_q;
        case (state_q)
            pfb_pkg::PFB_SEQ_IDLE: begin
                if (cmd.wr_pulse && (is_prog || is_erase)) begin
                    state_d  = pfb_pkg::PFB_SEQ_ARMED;
                    erase_d  = is_erase;
                end else if (cmd.wr_pulse && code == pfb_pkg::CMD_CLEAR_STATUS) begin
                    status_d  = pfb_pkg::STATUS_RESET;
                    aborted_d = 1'b0;
                end
            end
            pfb_pkg::PFB_SEQ_ARMED: begin
                if (cmd.wr_pulse) begin
                    if (!erase_q || code == pfb_pkg::CMD_CONFIRM) begin
                        state_d  = pfb_pkg::PFB_SEQ_BUSY;
                        status_d = 8'h00;
                        cnt_d    = erase_q ? pfb_pkg::BUSY_W'(pfb_pkg::ERASE_TIME_CYC)
                                           : pfb_pkg::BUSY_W'(pfb_pkg::PROG_TIME_CYC);
                    end else begin
                        state_d = pfb_pkg::PFB_SEQ_IDLE;
                    end
                end
            end
            pfb_pkg::PFB_SEQ_BUSY: begin
                // Deselect has no effect here; only reset or suspend stop the work.
                if (cmd.hard_reset) begin
                    state_d   = pfb_pkg::PFB_SEQ_ABORT;
                    cnt_d     = pfb_pkg::BUSY_W'(pfb_pkg::RESET_ABORT_CYC - 2);
                    aborted_d = 1'b1;
                end else if (cmd.wr_pulse && code == pfb_pkg::CMD_SUSPEND) begin
                    state_d  = pfb_pkg::PFB_SEQ_IDLE;
                    status_d = pfb_pkg::STATUS_READY_BIT;
                end else if (cnt_done) begin
                    state_d  = pfb_pkg::PFB_SEQ_IDLE;
                    status_d = pfb_pkg::STATUS_READY_BIT;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            pfb_pkg::PFB_SEQ_ABORT: begin
                // The busy output is registered one cycle late, so the count is cut short to end inside the abort time.
                if (cnt_done) begin
                    state_d  = pfb_pkg::PFB_SEQ_IDLE;
                    status_d = pfb_pkg::STATUS_RESET;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = pfb_pkg::PFB_SEQ_IDLE;
        endcase
        if (cmd.hard_reset && state_q != pfb_pkg::PFB_SEQ_BUSY && state_q != pfb_pkg::PFB_SEQ_ABORT) begin
            state_d  = pfb_pkg::PFB_SEQ_IDLE;
            status_d = pfb_pkg::STATUS_RESET;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q   <= pfb_pkg::PFB_SEQ_IDLE;
            cnt_q     <= '0;
            status_q  <= pfb_pkg::STATUS_RESET;
            erase_q   <= 1'b0;
            aborted_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            status_q  <= status_d;
            erase_q   <= erase_d;
            aborted_q <= aborted_d;
        end
    end

    assign cmd.busy    = state_q == pfb_pkg::PFB_SEQ_BUSY || state_q == pfb_pkg::PFB_SEQ_ABORT;
    assign cmd.aborted = aborted_q;
    assign cmd.status  = status_q;
endmodule : pfb_write_seq

//--- logic/pfb_bus_front.sv
// Bus front end of the parallel flash: operation decode, latches and pin drivers.
`timescale 1ns/1ps
module pfb_bus_front (
    input  wire logic                        ref_clk_in,
    input  wire logic                        resetn_in,
    input  wire logic                        hard_reset_n_in,
    input  wire logic                        chip_sel_n_in,
    input  wire logic                        out_en_n_in,
    input  wire logic                        write_n_in,
    input  wire logic                        address_valid_n_in,
    input  wire logic                        bus_clk_in,
    input  wire logic                        sync_mode_in,
    input  wire logic [pfb_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [pfb_pkg::DATA_W-1:0]  dq_in,
    input  wire logic [pfb_pkg::DATA_W-1:0]  array_data_in,
    output logic      [pfb_pkg::DATA_W-1:0]  dq_out,
    output logic                             dq_oe_out,
    output logic                             wait_out,
    output logic                             wait_oe_out,
    output logic      [pfb_pkg::ADDR_W-1:0]  array_addr_out,
    output logic      [pfb_pkg::BLOCK_W-1:0] block_sel_out,
    output logic                             standby_out,
    output logic                             busy_out,
    output logic                             aborted_out,
    output logic      [7:0]                  status_out
);
    // =========================================================
    // Operation decode
    // =========================================================
    pfb_cmd_if cmd ();

    function automatic pfb_pkg::pfb_op_t decode_op(input logic rst_n, input logic ce_n,
                                                   input logic oe_n, input logic we_n);
        if (!rst_n)
            decode_op = pfb_pkg::PFB_OP_RESET;
        else if (ce_n)
            decode_op = pfb_pkg::PFB_OP_STANDBY;
        else if (!we_n && oe_n)
            decode_op = pfb_pkg::PFB_OP_WRITE;
        else if (!oe_n && we_n)
            decode_op = pfb_pkg::PFB_OP_READ;
        else
            decode_op = pfb_pkg::PFB_OP_DISABLE;
    endfunction : decode_op

    wire pfb_pkg::pfb_op_t op_now = decode_op(hard_reset_n_in, chip_sel_n_in, out_en_n_in, write_n_in);
    wire is_read  = op_now == pfb_pkg::PFB_OP_READ;
    wire is_write = op_now == pfb_pkg::PFB_OP_WRITE;
    wire in_reset = op_now == pfb_pkg::PFB_OP_RESET;

    // =========================================================
    // Edge history of strobes
    // =========================================================
    logic adv_n_q;
    logic bclk_q;
    logic wr_active_q;
    logic wr_active_d;
    logic [pfb_pkg::ADDR_W-1:0] addr_q;
    logic [pfb_pkg::ADDR_W-1:0] addr_d;
    logic [pfb_pkg::ADDR_W-1:0] wr_addr_q;
    logic [pfb_pkg::DATA_W-1:0] wr_data_q;
    logic                       wr_pulse_q;

    wire adv_rise   = !adv_n_q && address_valid_n_in;
    wire bclk_rise  = !bclk_q && bus_clk_in;
    // Write end is the first of write strobe or chip select going high.
    wire wr_end     = wr_active_q && !is_write;
    // Clock edges captured only in sync mode and never during writes.
    wire sync_cap   = sync_mode_in && bclk_rise && !address_valid_n_in && write_n_in;
    wire async_flow = !sync_mode_in && !address_valid_n_in;

    always_comb begin
        addr_d = addr_q;
        if (async_flow)
            addr_d = addr_in;
        else if (adv_rise || sync_cap)
            addr_d = addr_in;
        if (in_reset)
            addr_d = '0;
    end
    assign wr_active_d = is_write;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adv_n_q     <= 1'b1;
            bclk_q      <= 1'b0;
            wr_active_q <= 1'b0;
            addr_q      <= '0;
        end else begin
            adv_n_q     <= address_valid_n_in;
            bclk_q      <= bus_clk_in;
            wr_active_q <= wr_active_d;
            addr_q      <= addr_d;
        end
    end

    // Write data is sampled every write cycle; the last sample stands at the end.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_addr_q  <= '0;
            wr_data_q  <= '0;
            wr_pulse_q <= 1'b0;
        end else begin
            wr_pulse_q <= wr_end && !in_reset;
            if (is_write) begin
                wr_addr_q <= addr_d;
                wr_data_q <= dq_in;
            end
        end
    end

    assign cmd.wr_pulse   = wr_pulse_q;
    assign cmd.wr_addr    = wr_addr_q;
    assign cmd.wr_data    = wr_data_q;
    assign cmd.hard_reset = in_reset;

    pfb_write_seq u_seq (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .cmd        (cmd)
    );

    // =========================================================
    // Pin drivers
    // =========================================================
    logic read_status_q;
    wire  cmd_code_rs = wr_pulse_q && wr_data_q[7:0] == pfb_pkg::CMD_READ_STATUS;
    wire  cmd_code_ra = wr_pulse_q && wr_data_q[7:0] == pfb_pkg::CMD_READ_ARRAY;
    wire [pfb_pkg::DATA_W-1:0] read_word = read_status_q ? {8'h00, cmd.status} : array_data_in;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            read_status_q  <= 1'b0;
            dq_out         <= '0;
            dq_oe_out      <= 1'b0;
            wait_out       <= 1'b0;
            wait_oe_out    <= 1'b0;
            array_addr_out <= '0;
            block_sel_out  <= '0;
            standby_out    <= 1'b0;
            busy_out       <= 1'b0;
            aborted_out    <= 1'b0;
            status_out     <= pfb_pkg::STATUS_RESET;
        end else begin
            if (in_reset || cmd_code_ra)
                read_status_q <= 1'b0;
            else if (cmd_code_rs || (wr_pulse_q && cmd.busy == 1'b0 && wr_data_q[7:0] != pfb_pkg::CMD_READ_ARRAY))
                read_status_q <= 1'b1;
            dq_out         <= is_read ? read_word : '0;
            dq_oe_out      <= is_read;
            wait_out       <= 1'b0;
            wait_oe_out    <= is_read && sync_mode_in;
            array_addr_out <= addr_q;
            block_sel_out  <= addr_q[pfb_pkg::ADDR_W-1:pfb_pkg::BLOCK_LSB];
            standby_out    <= op_now == pfb_pkg::PFB_OP_STANDBY && !cmd.busy;
            busy_out       <= cmd.busy;
            aborted_out    <= cmd.aborted;
            status_out     <= cmd.status;
        end
    end
endmodule : pfb_bus_front

//--- tb/pfb_bus_front_assertions.sv
// Checker of the pin behaviour of the flash bus front end.
`timescale 1ns/1ps
module pfb_bus_front_assertions (
    input wire logic                        ref_clk_in,
    input wire logic                        resetn_in,
    input wire logic                        hard_reset_n_in,
    input wire logic                        chip_sel_n_in,
    input wire logic                        out_en_n_in,
    input wire logic                        write_n_in,
    input wire logic                        address_valid_n_in,
    input wire logic                        sync_mode_in,
    input wire logic [pfb_pkg::ADDR_W-1:0]  addr_in,
    input wire logic                        dq_oe_out,
    input wire logic                        wait_out,
    input wire logic                        wait_oe_out,
    input wire logic [pfb_pkg::ADDR_W-1:0]  array_addr_out,
    input wire logic [pfb_pkg::BLOCK_W-1:0] block_sel_out,
    input wire logic                        standby_out,
    input wire logic                        busy_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    wire rd = hard_reset_n_in && !chip_sel_n_in && !out_en_n_in && write_n_in;
    wire flow = hard_reset_n_in && !address_valid_n_in && !sync_mode_in;
    a_read_drive: assert property (rd |=> dq_oe_out) else $error("read did not drive data");
    a_oe_float: assert property (out_en_n_in |=> !dq_oe_out && !wait_oe_out) else $error("drive with oe high");
    a_cs_float: assert property (chip_sel_n_in |=> !dq_oe_out && !wait_oe_out) else $error("drive in standby");
    a_reset_float: assert property (!hard_reset_n_in |=> !dq_oe_out && !wait_oe_out) else $error("drive in reset");
    a_addr_flow: assert property (flow |=> ##1 array_addr_out == $past(addr_in, 2) &&
        block_sel_out == array_addr_out[pfb_pkg::ADDR_W-1:pfb_pkg::BLOCK_LSB]) else $error("address not passed");
    a_wait_async: assert property (rd && !sync_mode_in |=> !wait_oe_out) else $error("wait driven async");
    a_wait_sync: assert property (rd && sync_mode_in |=> wait_oe_out) else $error("wait not driven sync");
    a_wait_level: assert property (wait_oe_out |-> !wait_out) else $error("wait asserted");
    a_reset_abort: assert property ($fell(hard_reset_n_in) |-> ##[0:626] !busy_out) else $error("abort too slow");
    a_cs_active: assert property (!chip_sel_n_in |=> !standby_out) else $error("standby while selected");
endmodule : pfb_bus_front_assertions
bind pfb_bus_front pfb_bus_front_assertions pfb_bus_front_assertions_i (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hard_reset_n_in(hard_reset_n_in),
    .chip_sel_n_in(chip_sel_n_in), .out_en_n_in(out_en_n_in), .write_n_in(write_n_in),
    .address_valid_n_in(address_valid_n_in), .sync_mode_in(sync_mode_in), .addr_in(addr_in),
    .dq_oe_out(dq_oe_out), .wait_out(wait_out), .wait_oe_out(wait_oe_out), .array_addr_out(array_addr_out),
    .block_sel_out(block_sel_out), .standby_out(standby_out), .busy_out(busy_out));

//--- tb/pfb_host_model.sv
// Host processor model driving the flash bus, plus a simple array content model.
`timescale 1ns/1ps
module pfb_host_model #(
    parameter int RECOVER_CYC = 8
) (
    input  wire logic                       ref_clk_in,
    input  wire logic [pfb_pkg::ADDR_W-1:0] array_addr_in,
    input  wire logic [pfb_pkg::DATA_W-1:0] dq_data_in,
    input  wire logic                       dq_oe_in,
    output logic                            hard_reset_n_out,
    output logic                            chip_sel_n_out,
    output logic                            out_en_n_out,
    output logic                            write_n_out,
    output logic                            address_valid_n_out,
    output logic                            bus_clk_out,
    output logic                            sync_mode_out,
    output logic [pfb_pkg::ADDR_W-1:0]      addr_out,
    output logic [pfb_pkg::DATA_W-1:0]      dq_out,
    output logic [pfb_pkg::DATA_W-1:0]      array_data_out
);
    logic clk_run;
    // Array word is a fixed function of the address so the bench can predict it.
    assign array_data_out = array_addr_in[15:0] ^ 16'h5a3c;
    initial begin
        {chip_sel_n_out, out_en_n_out, write_n_out} = 3'h7;
        {hard_reset_n_out, address_valid_n_out, bus_clk_out, sync_mode_out, clk_run} = 5'h00;
        addr_out = 24'h000000;
        dq_out = 16'h0000;
    end
    // The bus clock stands still outside synchronous reads.
    always @(posedge ref_clk_in) if (clk_run) bus_clk_out <= !bus_clk_out;
    task automatic bus_write(input logic [23:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        addr_out <= a;
        dq_out <= d;
        chip_sel_n_out <= 1'b0;
        write_n_out <= 1'b0;
        @(posedge ref_clk_in);
        write_n_out <= 1'b1;
        chip_sel_n_out <= 1'b1;
        @(posedge ref_clk_in);
        dq_out <= ~d;
    endtask : bus_write
    task automatic bus_read(input logic [23:0] a, output logic [15:0] d, output logic oe);
        @(posedge ref_clk_in);
        addr_out <= a;
        chip_sel_n_out <= 1'b0;
        out_en_n_out <= 1'b0;
        clk_run <= sync_mode_out;
        repeat (5) @(posedge ref_clk_in);
        d = dq_data_in;
        oe = dq_oe_in;
        chip_sel_n_out <= 1'b1;
        out_en_n_out <= 1'b1;
        clk_run <= 1'b0;
    endtask : bus_read
    task automatic pulse_reset(input int n);
        hard_reset_n_out <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
        hard_reset_n_out <= 1'b1;
        repeat (RECOVER_CYC) @(posedge ref_clk_in);
    endtask : pulse_reset
endmodule : pfb_host_model

//--- tb/pfb_bus_front_test.sv
// Self-checking bench of the flash bus front end against the host model.
`timescale 1ns/1ps
module pfb_bus_front_test;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hr_n, cs_n, oe_n, we_n, adv_n, bclk, sync, dq_oe, wt, wt_oe, stby, busy, abrt;
    logic [23:0] addr, a_addr;
    logic [15:0] dq_i, dq_o, arr, rd;
    logic [7:0] bsel, stat;
    logic rd_oe;
    int n_fail = 0;
    int n_tests = 0;
    always #20 ref_clk_in = !ref_clk_in;
    pfb_host_model pfb_host_model_i (.ref_clk_in(ref_clk_in), .array_addr_in(a_addr), .dq_data_in(dq_o),
        .dq_oe_in(dq_oe), .hard_reset_n_out(hr_n), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n),
        .write_n_out(we_n), .address_valid_n_out(adv_n), .bus_clk_out(bclk), .sync_mode_out(sync),
        .addr_out(addr), .dq_out(dq_i), .array_data_out(arr));
    pfb_bus_front pfb_bus_front_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hard_reset_n_in(hr_n),
        .chip_sel_n_in(cs_n), .out_en_n_in(oe_n), .write_n_in(we_n), .address_valid_n_in(adv_n),
        .bus_clk_in(bclk), .sync_mode_in(sync), .addr_in(addr), .dq_in(dq_i), .array_data_in(arr),
        .dq_out(dq_o), .dq_oe_out(dq_oe), .wait_out(wt), .wait_oe_out(wt_oe), .array_addr_out(a_addr),
        .block_sel_out(bsel), .standby_out(stby), .busy_out(busy), .aborted_out(abrt), .status_out(stat));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic wait_busy(input logic v, input int lim);
        int k;
        k = 0;
        while (busy !== v && k < lim) begin
            @(posedge ref_clk_in);
            k++;
        end
    endtask : wait_busy
    task automatic t_read(input logic [23:0] a);
        pfb_host_model_i.bus_read(a, rd, rd_oe);
        check("read data", rd, a[15:0] ^ 16'h5a3c);
        check("read drive", {15'h0, rd_oe}, 16'h0001);
        check("block", {8'h0, bsel}, {8'h0, a[23:16]});
        check("wait drive", {15'h0, wt_oe}, {15'h0, pfb_host_model_i.sync_mode_out});
        check("wait level", {15'h0, wt}, 16'h0000);
    endtask : t_read
    task automatic t_program;
        pfb_host_model_i.bus_write(24'h000100, 16'h0040);
        pfb_host_model_i.bus_write(24'h000100, 16'h1234);
        wait_busy(1'b1, 8);
        check("prog busy", {15'h0, busy}, 16'h0001);
        check("busy standby", {15'h0, stby}, 16'h0000);
        wait_busy(1'b0, 200);
        check("prog done", {8'h0, stat}, 16'h0080);
        check("idle standby", {15'h0, stby}, 16'h0001);
        pfb_host_model_i.bus_read(24'h000100, rd, rd_oe);
        check("status read", {8'h0, rd[7:0]}, 16'h0080);
        pfb_host_model_i.bus_write(24'h000100, 16'h00ff);
        t_read(24'hab00f0);
    endtask : t_program
    task automatic t_abort;
        pfb_host_model_i.bus_write(24'h050000, 16'h0020);
        pfb_host_model_i.bus_write(24'h050000, 16'h00d0);
        wait_busy(1'b1, 8);
        check("erase busy", {15'h0, busy}, 16'h0001);
        pfb_host_model_i.hard_reset_n_out <= 1'b0;
        pfb_host_model_i.bus_read(24'h050000, rd, rd_oe);
        check("reset float", {15'h0, rd_oe}, 16'h0000);
        pfb_host_model_i.pulse_reset(700);
        check("abort done", {15'h0, busy}, 16'h0000);
        check("abort flag", {15'h0, abrt}, 16'h0001);
        check("reset status", {8'h0, stat}, 16'h0080);
        pfb_host_model_i.bus_write(24'h050000, 16'h0050);
        repeat (4) @(posedge ref_clk_in);
        check("abort clear", {15'h0, abrt}, 16'h0000);
        // Any command but read array, written while the sequencer is not busy, leaves reads on the status word.
        pfb_host_model_i.bus_write(24'h050000, 16'h00ff);
        t_read(24'h050042);
    endtask : t_abort
    task automatic t_sync;
        pfb_host_model_i.sync_mode_out <= 1'b1;
        pfb_host_model_i.bus_write(24'h000000, 16'h00ff);
        t_read(24'h7fc001);
        pfb_host_model_i.sync_mode_out <= 1'b0;
    endtask : t_sync
    initial begin
        #800000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        check("status init", {8'h0, stat}, 16'h0080);
        check("busy init", {15'h0, busy}, 16'h0000);
        pfb_host_model_i.pulse_reset(1);
        t_read(24'h123456);
        t_program();
        t_abort();
        t_sync();
        give_verdict();
    end
endmodule : pfb_bus_front_test
